// ---- hdl/stmoc_pkg.sv ----
package stmoc_pkg;
  // Register byte addresses on the 32-bit Wishbone bus
  localparam logic [7:0] ADDR_CTRL0  = 8'h00; // Counter on control
  localparam logic [7:0] ADDR_CTRL1  = 8'h04; // timer_control_one
  localparam logic [7:0] ADDR_CNT_LO = 8'h08; // counter_low_byte
  localparam logic [7:0] ADDR_CNT_HI = 8'h0C; // Counter high byte
  localparam logic [7:0] ADDR_CMPA_L = 8'h10; // Compare A low byte
  localparam logic [7:0] ADDR_CMPA_H = 8'h14; // Compare A high byte
  localparam logic [7:0] ADDR_CMPP   = 8'h18; // Compare P value
  localparam logic [7:0] ADDR_STAT   = 8'h1C; // Sticky event status
  localparam logic [7:0] ADDR_MASK   = 8'h20; // Interrupt mask
  // Control-one field positions
  localparam int MODE_HI  = 7;
  localparam int MODE_LO  = 6;
  localparam int PIN_HI   = 5;
  localparam int PIN_LO   = 4;
  localparam int INIT_BIT = 3;
  localparam int INV_BIT  = 2;
  localparam int SWAP_BIT = 1;
  localparam int CLR_BIT  = 0;
  localparam int ON_BIT   = 3; // In control zero
  // Status bit positions
  localparam int ST_A   = 0;
  localparam int ST_P   = 1;
  localparam int ST_CAP = 2;
  // Reset values
  localparam logic [7:0]  CTRL_RST = 8'h00;
  localparam logic [15:0] CNT_RST  = 16'h0000;
  localparam logic [2:0]  ST_RST   = 3'h0;
  // Operating modes
  typedef enum logic [1:0] {
    STMOC_CMP = 2'h0,
    STMOC_CAP = 2'h1,
    STMOC_PWM = 2'h2,
    STMOC_TMR = 2'h3
  } stmoc_mode_t;
endpackage : stmoc_pkg

// ---- hdl/stmoc_core.sv ----
// Function
// - PWM pin action: inactive, active, PWM, pulse
// - Capture edge: rise, fall, both, off
// - Compare A match sets, clears or toggles
// - Pin action zero leaves pin unchanged in compare mode
// - Request equal to initial level: no change
// - Pin action change restores initial level in compare mode
// - Initial level bit sets compare start level
// - Initial level bit sets PWM active level
// - Invert bit inverts pin in every mode, driven in compare and PWM only
// - Swap bit exchanges period and duty roles
// - Clear select: A match, else P/overflow
// - Overflow clears only with P zero in compare and timer modes
// - Clear select ignored in PWM and capture
// - Counter low byte reads live counter
// - Mode field selects four operating modes
// - Counter-on rise zeroes counter, restores pin in compare mode
// - P compares top eight counter bits
`timescale 1ns/100ps
`default_nettype none
module stmoc_core (
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        tick_en,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        timer_pin_i,
  output logic             timer_pin_o,
  output logic             timer_pin_oe,
  output logic      [15:0] capture_value,
  output logic             irq
);
  logic [7:0]  ctrl0_reg;        // Counter on lives in bit 3
  logic [7:0]  timer_control_one; // Mode and pin control
  logic [15:0] cnt_reg;          // Live counter
  logic [15:0] compare_a_value;  // Compare A
  logic [7:0]  compare_p_value;  // Compare P, top byte only
  logic [2:0]  stat_reg;         // Sticky events
  logic [2:0]  mask_reg;         // Interrupt enables
  logic        pin_reg;          // Raw pin level before invert
  logic        on_d_reg;         // Counter on, delayed
  logic [1:0]  pin_act_d_reg;    // Pin action, delayed
  logic        in_d_reg;         // Pin input, delayed
  logic        pulse_done_reg;   // Single pulse has fired
  logic        a_hit_reg;        // A already matched this pass
  logic        ack_reg;          // Bus answer

  stmoc_pkg::stmoc_mode_t mode;
  logic [1:0] pin_action_select;
  logic       output_initial_level;
  logic       output_invert;
  logic       period_duty_swap;
  logic       counter_clear_select;
  logic       counter_on;
  logic       on_rise;      // Counter on edge
  logic       act_change;   // Pin action edit
  logic       a_match;      // Compare A equality
  logic       p_match;      // Compare P equality
  logic       a_event;      // Single event per pass
  logic       ovf;          // Counter at maximum
  logic       clr_cnt;      // Counter clear term
  logic       pwm_end;      // Period reached
  logic       pwm_act;      // Duty phase active
  logic       cap_evt;      // Capture edge seen
  logic       wr;           // Bus write strobe
  logic       rd_hit;       // Address decoded
  logic [7:0] rd_byte;      // Read mux
  logic [15:0] per_val;     // PWM period
  logic [15:0] duty_val;    // PWM duty

  // Field extraction
  assign mode = stmoc_pkg::stmoc_mode_t'(
    timer_control_one[stmoc_pkg::MODE_HI:stmoc_pkg::MODE_LO]);
  assign pin_action_select =
    timer_control_one[stmoc_pkg::PIN_HI:stmoc_pkg::PIN_LO];
  assign output_initial_level = timer_control_one[stmoc_pkg::INIT_BIT];
  assign output_invert        = timer_control_one[stmoc_pkg::INV_BIT];
  assign period_duty_swap     = timer_control_one[stmoc_pkg::SWAP_BIT];
  assign counter_clear_select = timer_control_one[stmoc_pkg::CLR_BIT];
  assign counter_on           = ctrl0_reg[stmoc_pkg::ON_BIT];
  assign on_rise    = counter_on & ~on_d_reg;
  assign act_change = pin_action_select != pin_act_d_reg;

  // Comparators
  assign a_match = tick_en & counter_on & (cnt_reg == compare_a_value);
  assign p_match = tick_en & counter_on & (compare_p_value != 8'h00)
                 & (cnt_reg[15:8] == compare_p_value)
                 & (cnt_reg[7:0] == 8'h00);
  assign a_event = a_match & ~a_hit_reg;
  assign ovf     = tick_en & counter_on & (cnt_reg == 16'hFFFF);

  // PWM roles
  always_comb begin
    if (period_duty_swap) begin
      per_val  = compare_a_value;
      duty_val = {compare_p_value, 8'h00};
    end else begin
      per_val  = {compare_p_value, 8'h00};
      duty_val = compare_a_value;
    end
  end
  assign pwm_end = tick_en & counter_on & (per_val != 16'h0000)
                 & (cnt_reg == per_val - 16'h0001);
  assign pwm_act = cnt_reg < duty_val;

  // Clear source selection
  always_comb begin
    if (mode == stmoc_pkg::STMOC_PWM) begin
      clr_cnt = pwm_end | ovf;
    end else if (mode == stmoc_pkg::STMOC_CAP) begin
      clr_cnt = ovf;
    end else if (counter_clear_select) begin
      clr_cnt = a_match;
    end else begin
      clr_cnt = p_match | (ovf & (compare_p_value == 8'h00));
    end
  end

  // Counter
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_reg <= stmoc_pkg::CNT_RST;
    end else if (on_rise) begin
      cnt_reg <= stmoc_pkg::CNT_RST;
    end else if (clr_cnt) begin
      cnt_reg <= stmoc_pkg::CNT_RST;
    end else if (tick_en & counter_on) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // Pass tracker for the A event
  always_ff @(posedge core_clk) begin
    if (rst) begin
      a_hit_reg <= 1'b0;
    end else if (on_rise | (tick_en & cnt_reg != compare_a_value)) begin
      a_hit_reg <= 1'b0;
    end else if (a_match) begin
      a_hit_reg <= 1'b1;
    end
  end

  // Edge history
  always_ff @(posedge core_clk) begin
    if (rst) begin
      on_d_reg      <= 1'b0;
      pin_act_d_reg <= 2'h0;
      in_d_reg      <= 1'b0;
    end else begin
      on_d_reg      <= counter_on;
      pin_act_d_reg <= pin_action_select;
      in_d_reg      <= timer_pin_i;
    end
  end

  // Output waveform
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_reg        <= 1'b0;
      pulse_done_reg <= 1'b0;
    end else begin
      unique case (mode)
        stmoc_pkg::STMOC_CMP: begin
          if (on_rise | act_change) begin
            pin_reg <= output_initial_level;
          end else if (a_event) begin
            unique case (pin_action_select)
              2'h0: pin_reg <= pin_reg;
              2'h1: pin_reg <= 1'b0;
              2'h2: pin_reg <= 1'b1;
              2'h3: pin_reg <= ~pin_reg;
            endcase
          end
        end
        stmoc_pkg::STMOC_PWM: begin
          // Active level is the initial level bit
          unique case (pin_action_select)
            2'h0: pin_reg <= ~output_initial_level;
            2'h1: pin_reg <= output_initial_level;
            2'h2: pin_reg <= counter_on & pwm_act ?
                             output_initial_level : ~output_initial_level;
            2'h3: pin_reg <= counter_on & ~pulse_done_reg & pwm_act ?
                             output_initial_level : ~output_initial_level;
          endcase
          if (on_rise) begin
            pulse_done_reg <= 1'b0;
          end else if (pwm_end & pin_action_select == 2'h3) begin
            pulse_done_reg <= 1'b1;
          end
        end
        default: pin_reg <= pin_reg;
      endcase
    end
  end
  // Invert stage, pin released in capture and timer modes
  assign timer_pin_o  = pin_reg ^ output_invert;
  assign timer_pin_oe = (mode == stmoc_pkg::STMOC_CMP)
                      | (mode == stmoc_pkg::STMOC_PWM);

  // Capture edge select
  always_comb begin
    unique case (pin_action_select)
      2'h0: cap_evt = timer_pin_i & ~in_d_reg;
      2'h1: cap_evt = ~timer_pin_i & in_d_reg;
      2'h2: cap_evt = timer_pin_i ^ in_d_reg;
      2'h3: cap_evt = 1'b0;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      capture_value <= stmoc_pkg::CNT_RST;
    end else if (mode == stmoc_pkg::STMOC_CAP & counter_on & cap_evt) begin
      capture_value <= cnt_reg;
    end
  end

  // Bus decode and write
  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_reg & wb_sel_i[0];
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl0_reg         <= stmoc_pkg::CTRL_RST;
      timer_control_one <= stmoc_pkg::CTRL_RST;
      compare_a_value   <= stmoc_pkg::CNT_RST;
      compare_p_value   <= stmoc_pkg::CTRL_RST;
      mask_reg          <= stmoc_pkg::ST_RST;
    end else if (wr) begin
      unique case (wb_adr_i)
        stmoc_pkg::ADDR_CTRL0:  ctrl0_reg <= wb_dat_i[7:0] & 8'hF8;
        stmoc_pkg::ADDR_CTRL1:  timer_control_one <= wb_dat_i[7:0];
        stmoc_pkg::ADDR_CMPA_L: compare_a_value[7:0] <= wb_dat_i[7:0];
        stmoc_pkg::ADDR_CMPA_H: compare_a_value[15:8] <= wb_dat_i[7:0];
        stmoc_pkg::ADDR_CMPP:   compare_p_value <= wb_dat_i[7:0];
        stmoc_pkg::ADDR_MASK:   mask_reg <= wb_dat_i[2:0];
        default: ; // Read-only or unmapped: ignored
      endcase
    end
  end

  // Sticky status, set wins over write-one clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stat_reg <= stmoc_pkg::ST_RST;
    end else begin
      stat_reg <= (stat_reg & ~((wr & wb_adr_i == stmoc_pkg::ADDR_STAT)
                                ? wb_dat_i[2:0] : 3'h0))
                | {(mode == stmoc_pkg::STMOC_CAP) & counter_on & cap_evt,
                   p_match & ~(counter_clear_select
                               & (mode == stmoc_pkg::STMOC_CMP
                                  | mode == stmoc_pkg::STMOC_TMR)),
                   a_event};
    end
  end
  assign irq = |(stat_reg & mask_reg);

  // Read mux
  always_comb begin
    rd_hit = 1'b1;
    unique case (wb_adr_i)
      stmoc_pkg::ADDR_CTRL0:  rd_byte = ctrl0_reg;
      stmoc_pkg::ADDR_CTRL1:  rd_byte = timer_control_one;
      stmoc_pkg::ADDR_CNT_LO: rd_byte = cnt_reg[7:0];
      stmoc_pkg::ADDR_CNT_HI: rd_byte = cnt_reg[15:8];
      stmoc_pkg::ADDR_CMPA_L: rd_byte = compare_a_value[7:0];
      stmoc_pkg::ADDR_CMPA_H: rd_byte = compare_a_value[15:8];
      stmoc_pkg::ADDR_CMPP:   rd_byte = compare_p_value;
      stmoc_pkg::ADDR_STAT:   rd_byte = {5'h00, stat_reg};
      stmoc_pkg::ADDR_MASK:   rd_byte = {5'h00, mask_reg};
      default: begin
        rd_hit  = 1'b0;
        rd_byte = 8'h00;
      end
    endcase
  end

  // One-cycle ack, read data registered
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ack_reg  <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_reg  <= wb_cyc_i & wb_stb_i & ~ack_reg;
      wb_dat_o <= rd_hit ? {24'h00_0000, rd_byte} : 32'h0000_0000;
    end
  end
  assign wb_ack_o = ack_reg;

  // Checks
  init_restore_a: assert property (@(posedge core_clk) disable iff (rst)
    (mode == stmoc_pkg::STMOC_CMP) & act_change & ~on_rise |=>
    pin_reg == $past(output_initial_level))
    else $error("pin not restored");
  on_rise_a: assert property (@(posedge core_clk) disable iff (rst)
    on_rise |=> cnt_reg == 16'h0000)
    else $error("counter not zeroed");
  keep_pin_a: assert property (@(posedge core_clk) disable iff (rst)
    (mode == stmoc_pkg::STMOC_CMP) & a_event & ~on_rise & ~act_change
    & pin_action_select == 2'h0 |=> $stable(pin_reg))
    else $error("pin moved");
  toggle_a: assert property (@(posedge core_clk) disable iff (rst)
    (mode == stmoc_pkg::STMOC_CMP) & a_event & ~on_rise & ~act_change
    & pin_action_select == 2'h3 |=> pin_reg != $past(pin_reg))
    else $error("no toggle");
  invert_a: assert property (@(posedge core_clk) disable iff (rst)
    timer_pin_o == (pin_reg ^ output_invert))
    else $error("invert wrong");
  clr_a_a: assert property (@(posedge core_clk) disable iff (rst)
    (mode == stmoc_pkg::STMOC_CMP) & counter_clear_select & a_match
    & ~on_rise |=> cnt_reg == 16'h0000)
    else $error("A clear missed");
  // With P nonzero only a P match may clear the counter
  ovf_a: assert property (@(posedge core_clk) disable iff (rst)
    (mode == stmoc_pkg::STMOC_CMP | mode == stmoc_pkg::STMOC_TMR)
    & ~counter_clear_select & compare_p_value != 8'h00 & ~p_match
    |-> ~clr_cnt)
    else $error("wrap wrong");
  // Level compared with the bit that produced it
  pwm_lvl_a: assert property (@(posedge core_clk) disable iff (rst)
    (mode == stmoc_pkg::STMOC_PWM) & pin_action_select == 2'h1
    & $stable(timer_control_one)
    |=> pin_reg == $past(output_initial_level))
    else $error("active level wrong");
  one_evt_a: assert property (@(posedge core_clk) disable iff (rst)
    a_event |=> ~a_event)
    else $error("double A event");
  low_byte_a: assert property (@(posedge core_clk) disable iff (rst)
    wb_cyc_i & wb_stb_i & ~ack_reg & wb_adr_i == stmoc_pkg::ADDR_CNT_LO
    |=> wb_dat_o[7:0] == $past(cnt_reg[7:0]))
    else $error("low byte wrong");
endmodule : stmoc_core
`default_nettype wire

// ---- tb/stmoc_pin_model.sv ----
`timescale 1ns/100ps
`default_nettype none
// Far side of the timer pin
module stmoc_pin_model (
  input  wire logic pin_o,
  input  wire logic pin_oe,
  input  wire logic ext_lvl,
  output logic      pin_i
);
  // Device wins while enabled, else the outside source drives
  always_comb begin
    pin_i = pin_oe ? pin_o : ext_lvl;
  end
endmodule : stmoc_pin_model
`default_nettype wire

// ---- tb/stmoc_core_tb_top.sv ----
`timescale 1ns/100ps
`default_nettype none
module stmoc_core_tb_top;
  logic        core_clk, rst, tick_en, cyc, stb, we, ack, irq;
  logic        pin_o, pin_oe, pin_i, ext_lvl;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat, rv;
  logic [15:0] cap;
  logic [15:0] rexp [4] = '{16'h3, 16'h3, 16'h5, 16'h7}; // After rise
  logic [15:0] fexp [4] = '{16'h3, 16'h6, 16'h7, 16'h7}; // After fall
  int          n_mismatch, check_count, cyc_cnt, hi;
  stmoc_core dut (.core_clk(core_clk), .rst(rst), .tick_en(tick_en),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .timer_pin_i(pin_i), .timer_pin_o(pin_o), .timer_pin_oe(pin_oe),
    .capture_value(cap), .irq(irq));
  stmoc_pin_model far (.pin_o(pin_o), .pin_oe(pin_oe), .ext_lvl(ext_lvl),
    .pin_i(pin_i));
  // Clock, 4 ns
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Compare and count
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // Verdict
  task report_and_stop;
    if (n_mismatch == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : report_and_stop
  // Classic cycle, held until ack
  task bus(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h000000, d};
    do @(posedge core_clk); while (ack !== 1'b1);
    rv = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : bus
  task wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'h1, a, d);
  endtask : wr
  task rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'h0, a, 8'h00);
    chk(rv, e);
  endtask : rd
  // Exactly n timer ticks
  task tk(input int n);
    repeat (n) begin
      @(posedge core_clk);
      tick_en <= 1'b1;
    end
    @(posedge core_clk);
    tick_en <= 1'b0;
  endtask : tk
  task w3;
    repeat (3) @(posedge core_clk);
  endtask : w3
  // Count pin cycles at level v
  task cnt(input int n, input logic v);
    hi = 0;
    repeat (n) begin
      @(posedge core_clk);
      if (pin_o === v) hi++;
    end
  endtask : cnt
  // Hang guard
  always @(posedge core_clk) begin
    cyc_cnt++;
    if (cyc_cnt > 20000) begin
      n_mismatch++;
      report_and_stop;
    end
  end
  initial begin
    rst = 1'b1;
    {tick_en, cyc, stb, we, ext_lvl} = 5'h00;
    adr = 8'h00;
    sel = 4'hF;
    wdat = 32'h0;
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    chk({pin_oe, pin_o, irq}, 3'h4);
    rd(stmoc_pkg::ADDR_CTRL1, 32'h0);
    rd(stmoc_pkg::ADDR_CNT_LO, 32'h0);
    rd(8'h24, 32'h0);
    // Counter low byte follows the live counter
    wr(stmoc_pkg::ADDR_CTRL1, 8'hC0);
    wr(stmoc_pkg::ADDR_CTRL0, 8'h08);
    tk(200);
    chk(pin_oe, 1'h0);
    rd(stmoc_pkg::ADDR_CNT_LO, 32'hC8);
    wr(stmoc_pkg::ADDR_CNT_LO, 8'h00);
    rd(stmoc_pkg::ADDR_CNT_LO, 32'hC8);
    rd(stmoc_pkg::ADDR_CNT_HI, 32'h0);
    // P match only at top byte
    wr(stmoc_pkg::ADDR_CMPP, 8'h01);
    wr(stmoc_pkg::ADDR_CTRL0, 8'h00);
    wr(stmoc_pkg::ADDR_CTRL0, 8'h08);
    wr(stmoc_pkg::ADDR_STAT, 8'h07);
    tk(255);
    bus(1'h0, stmoc_pkg::ADDR_STAT, 8'h00);
    chk(rv[stmoc_pkg::ST_P], 1'h0);
    // Match is taken on the tick that leaves count 0x0100
    tk(2);
    bus(1'h0, stmoc_pkg::ADDR_STAT, 8'h00);
    chk(rv[stmoc_pkg::ST_P], 1'h1);
    // Compare match output, drive high
    wr(stmoc_pkg::ADDR_CTRL0, 8'h00);
    wr(stmoc_pkg::ADDR_CMPA_L, 8'h03);
    wr(stmoc_pkg::ADDR_CMPP, 8'h00);
    wr(stmoc_pkg::ADDR_CTRL1, 8'h21);
    wr(stmoc_pkg::ADDR_STAT, 8'h07);
    wr(stmoc_pkg::ADDR_CTRL0, 8'h08);
    w3;
    chk(pin_o, 1'h0);
    tk(5);
    w3;
    chk({pin_o, irq}, 2'h2);
    rd(stmoc_pkg::ADDR_STAT, 32'h1);
    wr(stmoc_pkg::ADDR_MASK, 8'h01);
    w3;
    chk(irq, 1'h1);
    wr(stmoc_pkg::ADDR_STAT, 8'h01);
    w3;
    chk(irq, 1'h0);
    wr(stmoc_pkg::ADDR_CTRL1, 8'h11);
    w3;
    chk(pin_o, 1'h0);
    tk(5);
    w3;
    chk(pin_o, 1'h0);
    // Initial high, then drive low
    wr(stmoc_pkg::ADDR_CTRL0, 8'h00);
    wr(stmoc_pkg::ADDR_CTRL1, 8'h19);
    wr(stmoc_pkg::ADDR_CTRL0, 8'h08);
    w3;
    chk(pin_o, 1'h1);
    tk(5);
    w3;
    chk(pin_o, 1'h0);
    // No change, then inverted
    wr(stmoc_pkg::ADDR_CTRL0, 8'h00);
    wr(stmoc_pkg::ADDR_CTRL1, 8'h09);
    wr(stmoc_pkg::ADDR_CTRL0, 8'h08);
    tk(5);
    w3;
    chk(pin_o, 1'h1);
    wr(stmoc_pkg::ADDR_CTRL1, 8'h0D);
    w3;
    chk(pin_o, 1'h0);
    // Toggle
    wr(stmoc_pkg::ADDR_CTRL0, 8'h00);
    wr(stmoc_pkg::ADDR_CTRL1, 8'h31);
    wr(stmoc_pkg::ADDR_CTRL0, 8'h08);
    tk(5);
    w3;
    chk(pin_o, 1'h1);
    // PWM forced levels, changed only while stopped
    for (int i = 0; i < 4; i++) begin
      wr(stmoc_pkg::ADDR_CTRL0, 8'h00);
      wr(stmoc_pkg::ADDR_CTRL1, {2'h2, 1'h0, i[0], i[1], 3'h0});
      wr(stmoc_pkg::ADDR_CTRL0, 8'h08);
      w3;
      chk({pin_oe, pin_o}, {1'h1, i[0] ~^ i[1]});
    end
    // PWM waveform, period 256, duty 128
    wr(stmoc_pkg::ADDR_CTRL0, 8'h00);
    wr(stmoc_pkg::ADDR_CMPA_L, 8'h80);
    wr(stmoc_pkg::ADDR_CMPP, 8'h01);
    wr(stmoc_pkg::ADDR_CTRL1, 8'hA8);
    tick_en <= 1'b1;
    wr(stmoc_pkg::ADDR_CTRL0, 8'h08);
    repeat (300) @(posedge core_clk);
    cnt(512, 1'h1);
    chk(hi, 32'h100);
    // Swapped roles, inverted: period 1024, duty 256
    wr(stmoc_pkg::ADDR_CTRL0, 8'h00);
    wr(stmoc_pkg::ADDR_CMPA_L, 8'h00);
    wr(stmoc_pkg::ADDR_CMPA_H, 8'h04);
    wr(stmoc_pkg::ADDR_CTRL1, 8'hAE);
    wr(stmoc_pkg::ADDR_CTRL0, 8'h08);
    repeat (1100) @(posedge core_clk);
    cnt(1024, 1'h0);
    chk(hi, 32'h100);
    // Single pulse fires once
    wr(stmoc_pkg::ADDR_CTRL0, 8'h00);
    wr(stmoc_pkg::ADDR_CMPA_H, 8'h00);
    wr(stmoc_pkg::ADDR_CMPA_L, 8'h80);
    wr(stmoc_pkg::ADDR_CTRL1, 8'hB8);
    wr(stmoc_pkg::ADDR_CTRL0, 8'h08);
    cnt(2048, 1'h1);
    chk(hi > 0 && hi <= 256, 1'h1);
    tick_en <= 1'b0;
    // Capture edges for every pin action
    for (int a = 0; a < 4; a++) begin
      wr(stmoc_pkg::ADDR_CTRL1, {2'h1, a[1:0], 4'h0});
      chk(pin_oe, 1'h0);
      wr(stmoc_pkg::ADDR_CTRL0, 8'h00);
      wr(stmoc_pkg::ADDR_CTRL0, 8'h08);
      // Rise at count 3+a, fall two ticks later, unselected edges keep the last capture
      tk(3 + a);
      @(posedge core_clk);
      ext_lvl <= 1'b1;
      w3;
      chk(cap, rexp[a]);
      tk(2);
      @(posedge core_clk);
      ext_lvl <= 1'b0;
      w3;
      chk(cap, fexp[a]);
    end
    report_and_stop;
  end
endmodule : stmoc_core_tb_top
`default_nettype wire
